// file: design/rrse_pkg.sv
/*
 * Constants for the return, rotate and shift execution block: register
 * offsets, command and status field positions, operation and condition
 * codes, reset values and bus response codes.
 * Assumes a 32-bit AXI4-Lite register bus with 8-bit byte addresses.
 */
package rrse_pkg;

    // register byte offsets
    localparam logic [7:0] CMD_OFS   = 8'h00;
    localparam logic [7:0] STAT_OFS  = 8'h04;
    localparam logic [7:0] STACK_TOP_OFS = 8'h08;
    localparam logic [7:0] GPR_BASE  = 8'h40;
    localparam logic [7:0] GPR_MASK  = 8'hc3;

    // command word fields
    localparam int CMD_OP_LSB   = 0;
    localparam int CMD_OP_W     = 5;
    localparam int CMD_COND_LSB = 5;
    localparam int CMD_COND_W   = 3;
    localparam int CMD_REG_LSB  = 8;
    localparam int CMD_REG_W    = 4;
    localparam int CMD_EN_BIT   = 12;
    localparam int CMD_ADDR_LSB = 16;
    localparam int PC_W         = 10;
    localparam int SP_W         = 5;
    localparam int STK_DEPTH    = 32;
    localparam int GPR_NUM      = 16;

    // status word fields
    localparam int STAT_PC_LSB  = 0;
    localparam int STAT_C_BIT   = 16;
    localparam int STAT_Z_BIT   = 17;
    localparam int STAT_IE_BIT  = 18;
    localparam int STAT_PC_BIT  = 19;
    localparam int STAT_PZ_BIT  = 20;
    localparam int STAT_SP_LSB  = 24;

    // operation codes
    localparam logic [4:0] OP_NOP                  = 5'h00;
    localparam logic [4:0] OP_RET                  = 5'h01;
    localparam logic [4:0] INTERRUPT_RETURN_OP     = 5'h02;
    localparam logic [4:0] ROTATE_LEFT_OP          = 5'h03;
    localparam logic [4:0] ROTATE_RIGHT_OP         = 5'h04;
    localparam logic [4:0] SHIFT_LEFT_ZERO_FILL    = 5'h05;
    localparam logic [4:0] SHIFT_LEFT_ONE_FILL     = 5'h06;
    localparam logic [4:0] SHIFT_LEFT_REPLICATE    = 5'h07;
    localparam logic [4:0] SHIFT_LEFT_CARRY_FILL   = 5'h08;
    localparam logic [4:0] SHIFT_RIGHT_ZERO_FILL   = 5'h09;
    localparam logic [4:0] SHIFT_RIGHT_ONE_FILL    = 5'h0a;
    localparam logic [4:0] SHIFT_RIGHT_SIGN_EXTEND = 5'h0b;
    localparam logic [4:0] SHIFT_RIGHT_CARRY_FILL  = 5'h0c;
    localparam logic [4:0] OP_CALL                 = 5'h0d;
    localparam logic [4:0] OP_INTR                 = 5'h0e;
    localparam logic [4:0] OP_IEN                  = 5'h0f;

    // return condition codes
    localparam logic [2:0] COND_ALWAYS     = 3'h0;
    localparam logic [2:0] COND_CARRY_SET  = 3'h1;
    localparam logic [2:0] COND_CARRY_CLR  = 3'h2;
    localparam logic [2:0] COND_ZERO_SET   = 3'h3;
    localparam logic [2:0] COND_ZERO_CLEAR = 3'h4;

    // reset values and vector
    localparam logic [9:0] PC_RST     = 10'h000;
    localparam logic [9:0] INT_VECTOR = 10'h3ff;
    localparam logic [4:0] SP_RST     = 5'h00;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// file: design/rrse_exec.sv
/*
 * Execution of conditional return, interrupt return, rotates and shifts
 * for a small 8-bit core, with 16 data registers, a 10-bit program
 * counter and a circular call/return stack, driven over AXI4-Lite.
 * Assumes one clock, synchronous active-low reset, one write and one
 * read under way at a time.
 */
// The implementer's own choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
module rrse_exec
    import rrse_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output var  logic        awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output var  logic        wready,
    output var  logic [1:0]  bresp,
    output var  logic        bvalid,
    input  wire logic        bready,
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output var  logic        arready,
    output var  logic [31:0] rdata,
    output var  logic [1:0]  rresp,
    output var  logic        rvalid,
    input  wire logic        rready
);

    logic [7:0]      gpr [GPR_NUM];
    logic [PC_W-1:0] stk [STK_DEPTH];
    logic [PC_W-1:0] pc;
    logic [SP_W-1:0] sp;
    logic            carry;
    logic            zero;
    logic            int_en;
    logic            saved_carry;
    logic            saved_zero;

    logic            aw_hold;
    logic            w_hold;
    logic [7:0]      waddr_q;
    logic [31:0]     wdata_q;
    logic [3:0]      wstrb_q;

    logic [7:0]      next_res;
    logic            next_carry;
    logic [31:0]     stat_word;
    logic [31:0]     rd_word;

    // write decode
    wire             wr_go    = aw_hold & w_hold & ~bvalid;
    wire             w_is_cmd = (waddr_q == CMD_OFS);
    wire             w_is_gpr = ((waddr_q & GPR_MASK) == GPR_BASE);
    wire             wr_ok    = w_is_cmd | w_is_gpr;
    wire             wr_cmd   = wr_go & w_is_cmd & wstrb_q[0];
    wire             wr_gpr   = wr_go & w_is_gpr & wstrb_q[0];

    // command fields
    wire [4:0]       cmd_op   = wdata_q[CMD_OP_LSB +: CMD_OP_W];
    wire [2:0]       cmd_cond = wdata_q[CMD_COND_LSB +: CMD_COND_W];
    wire [3:0]       cmd_reg  = wdata_q[CMD_REG_LSB +: CMD_REG_W];
    wire             cmd_en   = wdata_q[CMD_EN_BIT];
    wire [PC_W-1:0]  cmd_addr = wdata_q[CMD_ADDR_LSB +: PC_W];

    wire [7:0]       opnd     = gpr[cmd_reg];
    wire [SP_W-1:0]  sp_dec   = sp - SP_W'(1);
    wire [SP_W-1:0]  sp_inc   = sp + SP_W'(1);
    wire [PC_W-1:0]  pc_inc   = pc + PC_W'(1);
    wire [PC_W-1:0]  stack_top_entry = stk[sp_dec];

    wire             cond_true =
        (cmd_cond == COND_ALWAYS) |
        ((cmd_cond == COND_CARRY_SET) & carry) |
        ((cmd_cond == COND_CARRY_CLR) & ~carry) |
        ((cmd_cond == COND_ZERO_SET) & zero) |
        ((cmd_cond == COND_ZERO_CLEAR) & ~zero);

    wire             is_shift = (cmd_op >= ROTATE_LEFT_OP) &
                                (cmd_op <= SHIFT_RIGHT_CARRY_FILL);
    wire             is_left  = (cmd_op >= SHIFT_LEFT_ZERO_FILL) &
                                (cmd_op <= SHIFT_LEFT_CARRY_FILL);
    wire             do_intr  = wr_cmd & (cmd_op == OP_INTR) & int_en;
    wire             do_push  = (wr_cmd & (cmd_op == OP_CALL)) | do_intr;
    wire             do_shift = wr_cmd & is_shift;

    // left fill bit, replicate takes old bit 0
    wire             sl_fill  = (cmd_op == SHIFT_LEFT_ONE_FILL) |
        ((cmd_op == SHIFT_LEFT_REPLICATE) & opnd[0]) |
        ((cmd_op == SHIFT_LEFT_CARRY_FILL) & carry);
    // right fill bit, sign-extend keeps bit 7
    wire             sr_fill  = (cmd_op == SHIFT_RIGHT_ONE_FILL) |
        ((cmd_op == SHIFT_RIGHT_SIGN_EXTEND) & opnd[7]) |
        ((cmd_op == SHIFT_RIGHT_CARRY_FILL) & carry);
    wire             next_zero = (next_res == 8'h00);

    always_comb begin
        next_res   = opnd;
        next_carry = carry;
        if (cmd_op == ROTATE_LEFT_OP) begin
            next_res   = {opnd[6:0], opnd[7]};
            next_carry = opnd[7];
        end else if (cmd_op == ROTATE_RIGHT_OP) begin
            next_res   = {opnd[0], opnd[7:1]};
            next_carry = opnd[0];
        end else if (is_left) begin
            next_res   = {opnd[6:0], sl_fill};
            next_carry = opnd[7];
        end else if (is_shift) begin
            next_res   = {sr_fill, opnd[7:1]};
            next_carry = opnd[0];
        end
    end

    // core state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pc          <= PC_RST;
            sp          <= SP_RST;
            carry       <= 1'b0;
            zero        <= 1'b0;
            int_en      <= 1'b0;
            saved_carry <= 1'b0;
            saved_zero  <= 1'b0;
        end else if (wr_cmd) begin
            case (cmd_op)
                OP_RET: begin
                    if (cond_true) begin
                        pc <= stack_top_entry + PC_W'(1);
                        sp <= sp_dec;
                    end else begin
                        pc <= pc_inc;
                    end
                end
                INTERRUPT_RETURN_OP: begin
                    pc     <= stack_top_entry;
                    sp     <= sp_dec;
                    carry  <= saved_carry;
                    zero   <= saved_zero;
                    int_en <= cmd_en;
                end
                OP_CALL: begin
                    pc <= cmd_addr;
                    sp <= sp_inc;
                end
                OP_INTR: begin
                    if (int_en) begin
                        pc          <= INT_VECTOR;
                        sp          <= sp_inc;
                        saved_carry <= carry;
                        saved_zero  <= zero;
                        int_en      <= 1'b0;
                    end
                end
                OP_IEN: begin
                    int_en <= cmd_en;
                end
                default: begin
                    if (is_shift) begin
                        carry <= next_carry;
                        zero  <= next_zero;
                        pc    <= pc_inc;
                    end
                end
            endcase
        end
    end

    // stack contents survive reset; only the pointer clears
    always_ff @(posedge aclk) begin
        if (do_push) begin
            stk[sp] <= pc;
        end
    end

    always_ff @(posedge aclk) begin
        if (wr_gpr) begin
            gpr[waddr_q[5:2]] <= wdata_q[7:0];
        end else if (do_shift) begin
            gpr[cmd_reg] <= next_res;
        end
    end

    // write channels, response after both address and data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b1;
            wready  <= 1'b1;
            aw_hold <= 1'b0;
            w_hold  <= 1'b0;
            bvalid  <= 1'b0;
            bresp   <= RESP_OKAY;
            waddr_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end else begin
            if (awvalid && awready) begin
                awready <= 1'b0;
                aw_hold <= 1'b1;
                waddr_q <= awaddr;
            end
            if (wvalid && wready) begin
                wready  <= 1'b0;
                w_hold  <= 1'b1;
                wdata_q <= wdata;
                wstrb_q <= wstrb;
            end
            if (wr_go) begin
                bvalid  <= 1'b1;
                bresp   <= wr_ok ? RESP_OKAY : RESP_SLVERR;
                aw_hold <= 1'b0;
                w_hold  <= 1'b0;
            end else if (bvalid && bready) begin
                bvalid  <= 1'b0;
                awready <= 1'b1;
                wready  <= 1'b1;
            end
        end
    end

    // read data selection
    wire r_is_cmd  = (araddr == CMD_OFS);
    wire r_is_stat = (araddr == STAT_OFS);
    wire r_is_top  = (araddr == STACK_TOP_OFS);
    wire r_is_gpr  = ((araddr & GPR_MASK) == GPR_BASE);
    wire rd_ok     = r_is_cmd | r_is_stat | r_is_top | r_is_gpr;

    always_comb begin
        stat_word = 32'h0000_0000;
        stat_word[STAT_PC_LSB +: PC_W] = pc;
        stat_word[STAT_C_BIT]          = carry;
        stat_word[STAT_Z_BIT]          = zero;
        stat_word[STAT_IE_BIT]         = int_en;
        stat_word[STAT_PC_BIT]         = saved_carry;
        stat_word[STAT_PZ_BIT]         = saved_zero;
        stat_word[STAT_SP_LSB +: SP_W] = sp;
        rd_word = 32'h0000_0000;
        if (r_is_stat) begin
            rd_word = stat_word;
        end else if (r_is_top) begin
            rd_word[PC_W-1:0] = stack_top_entry;
        end else if (r_is_gpr) begin
            rd_word[7:0] = gpr[araddr[5:2]];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= 32'h0000_0000;
            rresp   <= RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rdata   <= rd_word;
            rresp   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid && rready) begin
            rvalid  <= 1'b0;
            arready <= 1'b1;
        end
    end

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    ret_taken_pc_a: assert property (
        wr_cmd && cmd_op == OP_RET && cond_true |=>
            pc == $past(stack_top_entry) + PC_W'(1) && sp == $past(sp_dec))
        else $error("taken return did not load top plus one");

    ret_skip_pc_a: assert property (
        wr_cmd && cmd_op == OP_RET && !cond_true |=>
            pc == $past(pc_inc) && sp == $past(sp))
        else $error("untaken return changed more than pc");

    ret_cond_nc_a: assert property (
        wr_cmd && cmd_op == OP_RET && cmd_cond == COND_CARRY_CLR && carry
            |=> pc == $past(pc_inc))
        else $error("no-carry return taken with carry set");

    ret_cond_zclr_a: assert property (
        wr_cmd && cmd_op == OP_RET && cmd_cond == COND_ZERO_CLEAR && !zero
            |=> sp == $past(sp_dec))
        else $error("zero-clear return not taken");

    ret_flags_kept_a: assert property (
        wr_cmd && cmd_op == OP_RET |=>
            $stable(carry) && $stable(zero))
        else $error("return altered carry or zero");

    reti_restore_a: assert property (
        wr_cmd && cmd_op == INTERRUPT_RETURN_OP |=>
            pc == $past(stack_top_entry) && sp == $past(sp_dec) &&
            carry == $past(saved_carry) && zero == $past(saved_zero))
        else $error("interrupt return restore wrong");

    reti_ie_a: assert property (
        wr_cmd && cmd_op == INTERRUPT_RETURN_OP |=> int_en == $past(cmd_en))
        else $error("interrupt return enable wrong");

    rotate_left_a: assert property (
        wr_cmd && cmd_op == ROTATE_LEFT_OP |=>
            gpr[$past(cmd_reg)] == {$past(opnd[6:0]), $past(opnd[7])} &&
            carry == $past(opnd[7]) &&
            zero == ($past(opnd) == 8'h00))
        else $error("rotate left result wrong");

    rotate_right_a: assert property (
        wr_cmd && cmd_op == ROTATE_RIGHT_OP |=>
            gpr[$past(cmd_reg)] == {$past(opnd[0]), $past(opnd[7:1])} &&
            carry == $past(opnd[0]))
        else $error("rotate right result wrong");

    shift_pc_a: assert property (
        wr_cmd && is_shift |=> pc == $past(pc_inc) && $stable(sp))
        else $error("shift did not advance pc by one");

    shl_carry_fill_a: assert property (
        wr_cmd && cmd_op == SHIFT_LEFT_CARRY_FILL |=>
            gpr[$past(cmd_reg)][0] == $past(carry) &&
            carry == $past(opnd[7]))
        else $error("carry-fill left shift wrong");

    shl_replicate_a: assert property (
        wr_cmd && cmd_op == SHIFT_LEFT_REPLICATE |=>
            gpr[$past(cmd_reg)] == {$past(opnd[6:0]), $past(opnd[0])})
        else $error("replicate left shift wrong");

    shl_one_zero_a: assert property (
        wr_cmd && cmd_op == SHIFT_LEFT_ONE_FILL |=>
            !zero && carry == $past(opnd[7]))
        else $error("one-fill left shift zero flag set");

    shr_sign_a: assert property (
        wr_cmd && cmd_op == SHIFT_RIGHT_SIGN_EXTEND |=>
            gpr[$past(cmd_reg)] == {$past(opnd[7]), $past(opnd[7:1])} &&
            carry == $past(opnd[0]))
        else $error("sign-extend right shift wrong");

    shr_one_zero_a: assert property (
        wr_cmd && cmd_op == SHIFT_RIGHT_ONE_FILL |=>
            !zero && gpr[$past(cmd_reg)][7])
        else $error("one-fill right shift wrong");

    int_entry_a: assert property (
        do_intr |=> stk[$past(sp)] == $past(pc) && pc == INT_VECTOR &&
            saved_carry == $past(carry) && !int_en)
        else $error("interrupt entry state wrong");

endmodule
`default_nettype wire

// file: sim/rrse_ref_model.sv
/*
 * Reference model of core state behind the command register: program
 * counter, flags, circular call/return stack and data registers.
 * Assumes the bench calls apply() once per accepted command word.
 */
`timescale 1ns/100ps
`default_nettype none
module rrse_ref_model
    import rrse_pkg::*;
;
    logic [9:0] pc;
    logic [4:0] sp;
    logic       c, z, ie, pcs, pzs;
    logic [9:0] stk [STK_DEPTH];
    logic [7:0] gpr [GPR_NUM];

    task automatic reset_state();
        pc  = PC_RST;
        sp  = SP_RST;
        {c, z, ie, pcs, pzs} = 5'h00;
    endtask

    function automatic logic [31:0] status();
        return {3'h0, sp, 3'h0, pzs, pcs, ie, z, c, 6'h00, pc};
    endfunction

    task automatic apply(input logic [31:0] cmd);
        logic [4:0] op;
        logic [2:0] cd;
        logic [3:0] r;
        logic [7:0] v;
        logic [7:0] res;
        logic       fill;
        logic       hit;
        op = cmd[4:0];
        cd = cmd[7:5];
        r  = cmd[11:8];
        v  = gpr[r];
        fill = 1'b0;
        hit = (cd == COND_ALWAYS) || (cd == COND_CARRY_SET && c)
            || (cd == COND_CARRY_CLR && !c) || (cd == COND_ZERO_SET && z)
            || (cd == COND_ZERO_CLEAR && !z);
        case (op)
            OP_RET: begin
                if (hit) begin
                    sp = sp - 5'h01;
                    pc = stk[sp] + 10'h001;
                end else begin
                    pc = pc + 10'h001;
                end
            end
            INTERRUPT_RETURN_OP: begin
                sp = sp - 5'h01;
                pc = stk[sp];
                c  = pcs;
                z  = pzs;
                ie = cmd[CMD_EN_BIT];
            end
            OP_CALL: begin
                stk[sp] = pc;
                sp = sp + 5'h01;
                pc = cmd[25:16];
            end
            OP_INTR: begin
                if (ie) begin
                    stk[sp] = pc;
                    sp  = sp + 5'h01;
                    pcs = c;
                    pzs = z;
                    ie  = 1'b0;
                    pc  = INT_VECTOR;
                end
            end
            OP_IEN: ie = cmd[CMD_EN_BIT];
            ROTATE_LEFT_OP: fill = v[7];
            ROTATE_RIGHT_OP: fill = v[0];
            SHIFT_LEFT_ONE_FILL, SHIFT_RIGHT_ONE_FILL: fill = 1'b1;
            SHIFT_LEFT_REPLICATE: fill = v[0];
            SHIFT_RIGHT_SIGN_EXTEND: fill = v[7];
            SHIFT_LEFT_CARRY_FILL, SHIFT_RIGHT_CARRY_FILL: fill = c;
            default: ;
        endcase
        if (op >= ROTATE_LEFT_OP && op <= SHIFT_RIGHT_CARRY_FILL) begin
            if (op == ROTATE_LEFT_OP || (op >= SHIFT_LEFT_ZERO_FILL
                    && op <= SHIFT_LEFT_CARRY_FILL)) begin
                res = {v[6:0], fill};
                c   = v[7];
            end else begin
                res = {fill, v[7:1]};
                c   = v[0];
            end
            z = (res == 8'h00);
            gpr[r] = res;
            pc = pc + 10'h001;
        end
    endtask
endmodule
`default_nettype wire

// file: sim/return_rotate_shift_exec_tb.sv
/*
 * Self-checking bench: commands over AXI4-Lite, state read back.
 * Assumes the reference model mirrors every accepted command.
 */
`timescale 1ns/100ps
`default_nettype none
module return_rotate_shift_exec_tb
    import rrse_pkg::*;
;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, r;
    logic [7:0]  fv [4];
    int          error_cnt, samples_checked, i, k;

    rrse_exec rrse_exec_inst (.aclk(aclk), .aresetn(aresetn),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
    rrse_ref_model rrse_ref_model_inst ();

    task automatic finish_test();
        $display("errors %0d checks %0d", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk_word(string nm, logic [31:0] e, logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_resp(string nm, logic [1:0] e, logic [1:0] g);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic timeout();
        error_cnt++;
        $display("[FAIL] handshake expected answer seen none");
        finish_test();
    endtask

    task automatic axi_write(logic [7:0] a, logic [31:0] dd, logic [3:0] s,
                             output logic [1:0] resp);
        int n;
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= dd;
        wstrb   <= s;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (bvalid) break;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end
        if (n == 50) timeout();
        resp = bresp;
        bready <= 1'b0;
    endtask

    task automatic axi_read(logic [7:0] a, output logic [31:0] dd,
                            output logic [1:0] resp);
        int n;
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (rvalid) break;
            if (arvalid && arready) arvalid <= 1'b0;
        end
        if (n == 50) timeout();
        dd = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask

    function automatic logic [31:0] mk(logic [4:0] op, logic [2:0] cd,
                                       logic [3:0] rg, logic en,
                                       logic [9:0] ad);
        return {6'h00, ad, 3'h0, en, rg, cd, op};
    endfunction

    task automatic exec(logic [31:0] cmd);
        logic [1:0] rs;
        axi_write(CMD_OFS, cmd, 4'hf, rs);
        chk_resp("command response", RESP_OKAY, rs);
        rrse_ref_model_inst.apply(cmd);
    endtask

    task automatic wr_reg(logic [3:0] n, logic [7:0] v);
        logic [1:0] rs;
        axi_write(GPR_BASE + {2'b00, n, 2'b00}, {24'h0, v}, 4'hf, rs);
        chk_resp("register write response", RESP_OKAY, rs);
        rrse_ref_model_inst.gpr[n] = v;
    endtask

    task automatic chk_reg(logic [3:0] n);
        logic [31:0] dd;
        logic [1:0]  rs;
        axi_read(GPR_BASE + {2'b00, n, 2'b00}, dd, rs);
        chk_word("data register", {24'h0, rrse_ref_model_inst.gpr[n]}, dd);
        chk_resp("register read response", RESP_OKAY, rs);
    endtask

    task automatic check_state();
        logic [31:0] dd;
        logic [1:0]  rs;
        logic [9:0]  e;
        axi_read(STAT_OFS, dd, rs);
        chk_word("status", rrse_ref_model_inst.status(), dd);
        e = rrse_ref_model_inst.stk[rrse_ref_model_inst.sp - 5'h01];
        if (^e !== 1'bx) begin
            axi_read(STACK_TOP_OFS, dd, rs);
            chk_word("stack top", {22'h0, e}, dd);
        end
    endtask

    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end

    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        {awaddr, araddr, wdata, wstrb} = '0;
        fv = '{8'h80, 8'h01, 8'h00, 8'hc0};
        error_cnt = 0;
        samples_checked = 0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        rrse_ref_model_inst.reset_state();
        check_state();
        for (i = 3; i <= 12; i++) begin
            for (k = 0; k < 4; k++) begin
                wr_reg(4'(i), fv[k] ^ 8'(i << 2));
                exec(mk(5'(i), 3'h0, 4'(i), 1'b0, 10'h000));
                check_state();
                chk_reg(4'(i));
            end
        end
        for (i = 0; i < 8; i++) begin
            for (k = 0; k < 4; k++) begin
                wr_reg(4'h1, fv[k]);
                exec(mk(SHIFT_LEFT_ZERO_FILL, 3'h0, 4'h1, 1'b0, 10'h000));
                exec(mk(OP_CALL, 3'h0, 4'h0, 1'b0, 10'(37 * i + k + 16)));
                exec(mk(OP_RET, 3'(i), 4'h0, 1'b0, 10'h000));
                check_state();
            end
        end
        for (i = 0; i < 2; i++) begin
            exec(mk(OP_IEN, 3'h0, 4'h0, 1'b0, 10'h000));
            exec(mk(OP_INTR, 3'h0, 4'h0, 1'b0, 10'h000));
            check_state(); // masked entry
            exec(mk(OP_IEN, 3'h0, 4'h0, 1'b1, 10'h000));
            wr_reg(4'h2, 8'hc0);
            exec(mk(SHIFT_LEFT_ZERO_FILL, 3'h0, 4'h2, 1'b0, 10'h000));
            exec(mk(OP_INTR, 3'h0, 4'h0, 1'b0, 10'h000));
            check_state(); // entry
            wr_reg(4'h2, 8'h00);
            exec(mk(SHIFT_LEFT_ZERO_FILL, 3'h0, 4'h2, 1'b0, 10'h000));
            exec(mk(INTERRUPT_RETURN_OP, 3'h0, 4'h0, 1'(i), 10'h000));
            check_state();
        end
        axi_read(8'h20, d, r);
        chk_resp("unmapped read", RESP_SLVERR, r);
        chk_word("unmapped data", 32'h0, d);
        axi_write(8'h20, 32'h0000_0003, 4'hf, r);
        chk_resp("unmapped write", RESP_SLVERR, r);
        axi_write(STAT_OFS, 32'h0000_0003, 4'hf, r);
        chk_resp("status write", RESP_SLVERR, r);
        wr_reg(4'h0, 8'h33);
        axi_write(GPR_BASE, 32'h0000_0055, 4'he, r);
        chk_resp("masked write", RESP_OKAY, r);
        chk_reg(4'h0);
        axi_read(CMD_OFS, d, r);
        chk_word("command read", 32'h0, d);
        check_state();
        finish_test();
    end
endmodule
`default_nettype wire
